// [shared/cec_cfg.svh]
// constants of the crypto engine control, status and key-storage block
// assumes inclusion by bare name from the package only; the design module uses its macros without including it
//
// Function
// - op codes 1111 load key, 1110 encrypt key, 1011 gen key, 1010 random
// - op codes 0000 encrypt, 0001 decrypt, 0010 key expansion; 1001 reserved
// - cipher select bit 3: 1 routes to AES, 0 to DES
// - chaining 000 ECB, 001 CBC, 010 CFB, 011 OFB, 100 CTR; rest reserved
// - selection fields clear on reset and while power-disable is set
// - selection field writes ignored while operation-go is set
// - idle entry with idle-stop set halts the running operation
// - status bit 7 reads 1 while an operation runs
// - status bit 6 reads 1 while text register A is busy
// - aborted flag bit 5 set on software stop; blocks new operations
// - counter-wrap flag bit 4 set on CTR wrap; blocks go until cleared
// - aborted and wrap flags clear on power-disable and on go clear
// - mode fault bit 2 while op/cipher/chaining invalid; blocks program-write
// - key fault bit 1 while key/mode invalid; blocks program-write
// - page fault bit 0 when page reserved or, for the one-time array, locked; blocks programming
// - fault flags evaluate even while engine-on is 0
// - busy, key and page faults read set during every storage read
// - target bit 8: 1 programs key RAM, 0 the one-time array
// - program control bit 7 mirrors the programmed marker
// - irq enable bit 6 raises interrupt on storage op completion
// - storage-read bit 5 starts a read, hardware clears; resets to 1
// - page 0000 config page, 0001-1000 pages 1-8, higher reserved
// - go starts the operation, hardware clears on completion, software stops
// - engine-on 1 enables the module, 0 disables it
`ifndef CEC_CFG_SVH
`define CEC_CFG_SVH

// register byte offsets
`define CEC_ADDR_CTRL     12'h000
`define CEC_ADDR_STAT     12'h004
`define CEC_ADDR_PROG     12'h008

// control low field positions
`define CEC_CL_ON         15
`define CEC_CL_SIDL       13
`define CEC_CL_GO         8
`define CEC_CL_OP_HI      7
`define CEC_CL_OP_LO      4
`define CEC_CL_CPHR       3
`define CEC_CL_MODE_HI    2
`define CEC_CL_MODE_LO    0

// program control field positions
`define CEC_PC_TGT        8
`define CEC_PC_MARK       7
`define CEC_PC_IE         6
`define CEC_PC_RD         5
`define CEC_PC_PG_HI      4
`define CEC_PC_PG_LO      1
`define CEC_PC_WR         0

// operation codes
`define CEC_OP_ENC        4'h0
`define CEC_OP_DEC        4'h1
`define CEC_OP_KEXP       4'h2
`define CEC_OP_RAND       4'ha
`define CEC_OP_GENKEY     4'hb
`define CEC_OP_ENCKEY     4'he
`define CEC_OP_LOADKEY    4'hf

// chaining codes
`define CEC_MODE_ECB      3'h0
`define CEC_MODE_CBC      3'h1
`define CEC_MODE_CFB      3'h2
`define CEC_MODE_OFB      3'h3
`define CEC_MODE_CTR      3'h4

// pages and reset values
`define CEC_PAGE_LAST     4'h8
`define CEC_RD_RST        1'b1
`define CEC_OP_RST        4'h0
`define CEC_MODE_RST      3'h0

`endif

// [shared/cec_pkg.sv]
// types of the crypto engine control, status and key-storage block
// assumes cec_cfg.svh sits on the include path
package cec_pkg;
    `include "cec_cfg.svh"

    // AHB-Lite address phase seen by the slave
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
    } cec_ahb_req_type;

    // command towards the cipher datapath
    typedef struct packed {
        logic       start;
        logic       halt;
        logic [3:0] operation_select;
        logic       cipher_engine_select;
        logic [2:0] chaining_mode_select;
    } cec_engine_cmd_type;

    // request towards the key storage
    typedef struct packed {
        logic       req;
        logic       write;
        logic       target_ram;
        logic [3:0] page;
    } cec_stor_req_type;
endpackage

// [src/cec_ctrl.sv]
// control, status and key-storage program logic of the cipher engine
// assumes one AHB-Lite master, a datapath that pulses op_done and a storage
// array that pulses stor_done once per request
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module cec_ctrl
    import cec_pkg::*;
(
    // clock and reset
    input  wire logic               sys_clk,
    input  wire logic               rst,
    // register bus
    input  wire cec_ahb_req_type    ahb_in,
    input  wire logic [31:0]        hwdata,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    // system state
    input  wire logic               module_power_disable,
    input  wire logic               cpu_idle,
    // cipher datapath
    output cec_engine_cmd_type      engine_cmd,
    input  wire logic               op_done,
    input  wire logic               text_a_busy,
    input  wire logic               ctr_wrap,
    input  wire logic               key_cfg_invalid,
    // key storage
    output cec_stor_req_type        stor_req,
    input  wire logic               stor_done,
    input  wire logic [8:0]         page_locked,
    input  wire logic               programmed_marker,
    output logic                    stor_irq
);

    logic        engine_on;
    logic        idle_stop;
    logic        go;
    logic [3:0]  operation_select;
    logic        cipher_engine_select;
    logic [2:0]  chaining_mode_select;
    logic        aborted_flag;
    logic        counter_wrap_flag;
    logic        program_target_select;
    logic        storage_op_irq_enable;
    logic        storage_read;
    logic [3:0]  program_page_select;
    logic        program_write;
    logic        dph_wr;
    logic [11:0] dph_addr;
    logic        start_q;
    logic        halt_q;
    logic        aph;
    logic        wr_ctrl;
    logic        wr_prog;
    logic        mode_config_fault;
    logic        key_config_fault;
    logic        program_page_fault;
    logic        wr_mode_bad;
    logic        wr_page_bad;
    logic        halt;
    logic        go_set;
    logic        flag_clr;
    logic        abort_set;
    logic        wrap_set;
    logic        wr_set;
    logic        rd_set;
    logic [15:0] ctrl_word;
    logic [15:0] stat_word;
    logic [15:0] prog_word;
    logic [15:0] next_rdata;

    // bus slave never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign aph       = ahb_in.hsel && ahb_in.htrans[1] && ahb_in.hready;

    // write data arrives one cycle after its address
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dph_wr   <= 1'b0;
            dph_addr <= 12'h000;
        end else begin
            dph_wr   <= aph && ahb_in.hwrite;
            dph_addr <= ahb_in.haddr[11:0];
        end
    end

    assign wr_ctrl = dph_wr && (dph_addr == `CEC_ADDR_CTRL);
    assign wr_prog = dph_wr && (dph_addr == `CEC_ADDR_PROG);

    // op/cipher/chaining validity; also applied to the word being written
    function automatic logic cec_mode_bad(input logic [3:0] op, input logic cphr, input logic [2:0] chain);
        logic bad;
        bad = 1'b0;
        case (op)
            `CEC_OP_ENC,
            `CEC_OP_DEC:     bad = 1'b0;
            `CEC_OP_KEXP:    bad = !cphr;
            `CEC_OP_RAND,
            `CEC_OP_GENKEY,
            `CEC_OP_ENCKEY,
            `CEC_OP_LOADKEY: bad = 1'b0;
            default:         bad = 1'b1;
        endcase
        if (chain > `CEC_MODE_CTR) begin
            bad = 1'b1;
        end
        return bad;
    endfunction

    // reserved pages above 8; lock bits only guard the one-time array
    function automatic logic cec_page_bad(input logic [3:0] page, input logic to_ram, input logic [8:0] locked);
        logic bad;
        bad = 1'b0;
        if (page > `CEC_PAGE_LAST) begin
            bad = 1'b1;
        end else if (!to_ram) begin
            bad = locked[page];
        end
        return bad;
    endfunction

    // evaluated regardless of engine-on
    assign mode_config_fault  = cec_mode_bad(operation_select, cipher_engine_select, chaining_mode_select);
    // a word that sets go or program-write together with new fields is judged on both
    assign wr_mode_bad        = cec_mode_bad(hwdata[`CEC_CL_OP_HI:`CEC_CL_OP_LO], hwdata[`CEC_CL_CPHR],
                                             hwdata[`CEC_CL_MODE_HI:`CEC_CL_MODE_LO]);
    assign wr_page_bad        = cec_page_bad(hwdata[`CEC_PC_PG_HI:`CEC_PC_PG_LO], hwdata[`CEC_PC_TGT],
                                             page_locked);

    // key validity comes from the key-source tables outside
    assign key_config_fault = key_cfg_invalid;

    assign program_page_fault = cec_page_bad(program_page_select, program_target_select,
                                             page_locked);

    // stop causes: software stop, idle stop, module disable
    assign halt = go && ((wr_ctrl && !hwdata[`CEC_CL_GO]) ||
                         (idle_stop && cpu_idle) ||
                         !engine_on);
    assign abort_set = halt && !op_done;
    assign go_set    = !go && wr_ctrl && hwdata[`CEC_CL_GO] && engine_on && hwdata[`CEC_CL_ON] &&
                       !aborted_flag && !counter_wrap_flag &&
                       !mode_config_fault && !wr_mode_bad && !key_config_fault &&
                       !storage_read && !program_write;
    // writing go low while idle clears the sticky flags
    assign flag_clr  = wr_ctrl && !hwdata[`CEC_CL_GO] && !go;
    assign wrap_set  = go && ctr_wrap && (chaining_mode_select == `CEC_MODE_CTR);

    // engine-on and idle-stop stay writable during an operation
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            engine_on <= 1'b0;
            idle_stop <= 1'b0;
        end else if (module_power_disable) begin
            engine_on <= 1'b0;
            idle_stop <= 1'b0;
        end else if (wr_ctrl) begin
            engine_on <= hwdata[`CEC_CL_ON];
            idle_stop <= hwdata[`CEC_CL_SIDL];
        end
    end

    // selection fields, locked while an operation runs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            operation_select     <= `CEC_OP_RST;
            cipher_engine_select <= 1'b0;
            chaining_mode_select <= `CEC_MODE_RST;
        end else if (module_power_disable) begin
            operation_select     <= `CEC_OP_RST;
            cipher_engine_select <= 1'b0;
            chaining_mode_select <= `CEC_MODE_RST;
        end else if (wr_ctrl && !go) begin
            operation_select     <= hwdata[`CEC_CL_OP_HI:`CEC_CL_OP_LO];
            cipher_engine_select <= hwdata[`CEC_CL_CPHR];
            chaining_mode_select <= hwdata[`CEC_CL_MODE_HI:`CEC_CL_MODE_LO];
        end
    end

    // operation-go: completion wins over a stop in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            go <= 1'b0;
        end else if (module_power_disable) begin
            go <= 1'b0;
        end else if (go) begin
            go <= !(op_done || halt);
        end else begin
            go <= go_set;
        end
    end

    // one-cycle strobes to the datapath
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            start_q <= 1'b0;
            halt_q  <= 1'b0;
        end else begin
            start_q <= go_set && !module_power_disable;
            halt_q  <= abort_set && !module_power_disable;
        end
    end

    // sticky flags; a set wins over a go-clear write, power-disable wins over a set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aborted_flag      <= 1'b0;
            counter_wrap_flag <= 1'b0;
        end else if (module_power_disable) begin
            aborted_flag      <= 1'b0;
            counter_wrap_flag <= 1'b0;
        end else begin
            aborted_flag      <= abort_set || (aborted_flag && !flag_clr);
            counter_wrap_flag <= wrap_set || (counter_wrap_flag && !flag_clr);
        end
    end

    // software storage requests: only with engine on, go clear, never both; the reset read starts with engine off
    assign wr_set = wr_prog && hwdata[`CEC_PC_WR] && !hwdata[`CEC_PC_RD] &&
                    engine_on && !go && !storage_read && !program_write &&
                    !mode_config_fault && !key_config_fault && !program_page_fault && !wr_page_bad;
    assign rd_set = wr_prog && hwdata[`CEC_PC_RD] && !hwdata[`CEC_PC_WR] &&
                    engine_on && !go && !storage_read && !program_write;

    // program control fields
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            program_target_select <= 1'b0;
            storage_op_irq_enable <= 1'b0;
            program_page_select   <= 4'h0;
        end else if (module_power_disable) begin
            storage_op_irq_enable <= 1'b0;
            program_page_select   <= 4'h0;
        end else if (wr_prog && !storage_read && !program_write) begin
            program_target_select <= hwdata[`CEC_PC_TGT];
            storage_op_irq_enable <= hwdata[`CEC_PC_IE];
            program_page_select   <= hwdata[`CEC_PC_PG_HI:`CEC_PC_PG_LO];
        end
    end

    // read starts at power-on; survives power-disable so the array reloads
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            storage_read <= `CEC_RD_RST;
        end else if (storage_read) begin
            storage_read <= !stor_done;
        end else begin
            storage_read <= rd_set;
        end
    end

    // program-write, cleared by completion or power-disable
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            program_write <= 1'b0;
        end else if (module_power_disable) begin
            program_write <= 1'b0;
        end else if (program_write) begin
            program_write <= !stor_done;
        end else begin
            program_write <= wr_set;
        end
    end

    // completion interrupt pulse
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stor_irq <= 1'b0;
        end else begin
            stor_irq <= stor_done && (storage_read || program_write) && storage_op_irq_enable;
        end
    end

    // readback words
    assign ctrl_word = {engine_on, 1'b0, idle_stop, 4'h0, go, operation_select,
                        cipher_engine_select, chaining_mode_select};
    assign stat_word = {8'h00,
                        go || storage_read,
                        text_a_busy,
                        aborted_flag, counter_wrap_flag, 1'b0,
                        mode_config_fault,
                        key_config_fault || storage_read,
                        program_page_fault || storage_read};
    assign prog_word = {7'h00, program_target_select,
                        programmed_marker,
                        storage_op_irq_enable, storage_read, program_page_select, program_write};

    always_comb begin
        case (ahb_in.haddr[11:0])
            `CEC_ADDR_CTRL: next_rdata = ctrl_word;
            `CEC_ADDR_STAT: next_rdata = stat_word;
            `CEC_ADDR_PROG: next_rdata = prog_word;
            default:        next_rdata = 16'h0000;
        endcase
    end

    // read data captured at the address phase, stands through the data phase
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hrdata <= 32'h0000_0000;
        end else if (aph && !ahb_in.hwrite) begin
            hrdata <= {16'h0000, next_rdata};
        end
    end

    // outputs to the datapath and storage
    assign engine_cmd.start                = start_q;
    assign engine_cmd.halt                 = halt_q;
    assign engine_cmd.operation_select     = operation_select;
    assign engine_cmd.cipher_engine_select = cipher_engine_select;
    assign engine_cmd.chaining_mode_select = chaining_mode_select;
    assign stor_req.req        = storage_read || program_write;
    assign stor_req.write      = program_write;
    assign stor_req.target_ram = program_target_select;
    assign stor_req.page       = program_page_select;

    sequence s_rd_done;
        storage_read && stor_done && storage_op_irq_enable;
    endsequence
    sequence s_irq_pulse;
        stor_irq ##1 !stor_irq;
    endsequence

    property p_start;
        @(posedge sys_clk) disable iff (rst)
        go_set && !module_power_disable |=> go && engine_cmd.start ##1 !engine_cmd.start;
    endproperty
    a_start: assert property (p_start) else $error("go start strobe wrong");

    property p_lock;
        @(posedge sys_clk) disable iff (rst)
        go && wr_ctrl && !module_power_disable |=> $stable(operation_select) && $stable(chaining_mode_select);
    endproperty
    a_lock: assert property (p_lock) else $error("fields changed during operation");

    property p_abort;
        @(posedge sys_clk) disable iff (rst)
        go && wr_ctrl && !hwdata[`CEC_CL_GO] && !op_done && !module_power_disable |=> aborted_flag && !go;
    endproperty
    a_abort: assert property (p_abort) else $error("software stop did not abort");

    property p_wrap_block;
        @(posedge sys_clk) disable iff (rst)
        counter_wrap_flag && !go |=> !go;
    endproperty
    a_wrap_block: assert property (p_wrap_block) else $error("go set with wrap flag");

    property p_fault_block;
        @(posedge sys_clk) disable iff (rst)
        !program_write && (mode_config_fault || program_page_fault) |=> !program_write;
    endproperty
    a_fault_block: assert property (p_fault_block) else $error("write started on fault");

    property p_busy_read;
        @(posedge sys_clk) disable iff (rst)
        aph && !ahb_in.hwrite && ahb_in.haddr[11:0] == `CEC_ADDR_STAT |=> hrdata[7] == $past(go || storage_read);
    endproperty
    a_busy_read: assert property (p_busy_read) else $error("busy readback wrong");

    property p_pd;
        @(posedge sys_clk) disable iff (rst)
        module_power_disable |=> operation_select == `CEC_OP_RST && !cipher_engine_select && !go;
    endproperty
    a_pd: assert property (p_pd) else $error("power disable did not clear fields");

    property p_irq;
        @(posedge sys_clk) disable iff (rst)
        s_rd_done |=> s_irq_pulse and ##1 !storage_read;
    endproperty
    a_irq: assert property (p_irq) else $error("read completion irq wrong");

    property p_idle;
        @(posedge sys_clk) disable iff (rst)
        go && idle_stop && cpu_idle && !op_done |=> !go ##1 !go;
    endproperty
    a_idle: assert property (p_idle) else $error("idle stop ignored");

endmodule

// [bench/cec_ctrl_bench.sv]
// self-checking bench of the cipher engine control and key-storage block
// assumes the bench is the only AHB-Lite master and answers every storage
// request and each datapath operation it does not stop with single-cycle done pulses
`timescale 1ns/1ps
module cec_ctrl_bench
    import cec_pkg::*;
;
    // bus, system and datapath stimulus
    logic               sys_clk, rst, hsel, hwrite, cpu_idle, pwr_dis;
    logic               op_done, txa_busy, ctr_wrap, key_bad, stor_done, marker;
    logic               hreadyout, hresp, stor_irq;
    logic [1:0]         htrans;
    logic [2:0]         hsize;
    logic [8:0]         locked;
    logic [31:0]        haddr, hwdata, hrdata, rd;
    cec_ahb_req_type    ahb;
    cec_engine_cmd_type cmd;
    cec_stor_req_type   sreq;
    int                 miscompares = 0, cmp_count = 0, starts = 0, halts = 0, irqs = 0;

    // single slave, so its ready is the bus ready
    assign ahb = {hsel, haddr, htrans, hwrite, hsize, hreadyout};

    cec_ctrl u_dut (
        .sys_clk(sys_clk), .rst(rst), .ahb_in(ahb), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .module_power_disable(pwr_dis),
        .cpu_idle(cpu_idle), .engine_cmd(cmd), .op_done(op_done), .text_a_busy(txa_busy),
        .ctr_wrap(ctr_wrap), .key_cfg_invalid(key_bad), .stor_req(sreq), .stor_done(stor_done),
        .page_locked(locked), .programmed_marker(marker), .stor_irq(stor_irq)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // pulses counted at the falling edge, settled before a task looks
    always @(negedge sys_clk) begin
        starts += int'(cmd.start === 1'b1);
        halts += int'(cmd.halt === 1'b1);
        irqs += int'(stor_irq === 1'b1);
    end

    task automatic test_done();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic wait_rdy();
        for (int n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (hreadyout === 1'b1) return;
        end
        miscompares++;
        test_done();
    endtask

    // one single word transfer, then an idle cycle so a read sees the last write
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, a};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // 0 op done, 1 storage done, 2 counter wrap, 3 power disable
    task automatic pulse(input int k);
        op_done <= (k == 0);
        stor_done <= (k == 1);
        ctr_wrap <= (k == 2);
        pwr_dis <= (k == 3);
        @(posedge sys_clk);
        {op_done, stor_done, ctr_wrap, pwr_dis} <= 4'h0;
        @(posedge sys_clk);
    endtask

    initial begin
        {hsel, hwrite, cpu_idle, pwr_dis, op_done, txa_busy, ctr_wrap, key_bad} = 8'h0;
        {stor_done, marker, htrans, haddr, hwdata} = '0;
        hsize = 3'b010;
        locked = 9'h002;
        rst = 1'b1;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk(sreq.req, 32'h1);
        rdc(12'h004, 32'h83);
        rdc(12'h008, 32'h20);
        pulse(1);
        rdc(12'h004, 32'h00);
        rdc(12'h008, 32'h00);
        // every operation code with the AES engine
        for (int i = 0; i < 16; i++) begin
            wr(12'h000, i * 16 + 8);
            rdc(12'h004, {(i > 2 && i < 10) || i == 12 || i == 13, 2'b00});
            chk({cmd.operation_select, cmd.cipher_engine_select}, i * 2 + 1);
        end
        wr(12'h000, 32'h20);
        rdc(12'h004, 32'h04);
        for (int i = 0; i < 8; i++) begin
            wr(12'h000, 8 + i);
            rdc(12'h004, {i > 4, 2'b00});
            chk(cmd.chaining_mode_select, i);
        end
        // normal run, locked fields, hardware completion
        wr(12'h000, 32'h8000);
        wr(12'h000, 32'h8119);
        chk(starts, 1);
        rdc(12'h004, 32'h80);
        wr(12'h000, 32'h812c);
        rdc(12'h000, 32'h8119);
        pulse(0);
        rdc(12'h000, 32'h8019);
        rdc(12'h004, 32'h00);
        // software stop, then a refused restart
        wr(12'h000, 32'h8119);
        wr(12'h000, 32'h8019);
        rdc(12'h004, 32'h20);
        chk(halts, 1);
        wr(12'h000, 32'h8119);
        chk(starts, 2);
        wr(12'h000, 32'h8019);
        rdc(12'h004, 32'h00);
        // idle entry with idle stop set
        wr(12'h000, 32'ha119);
        cpu_idle <= 1'b1;
        @(posedge sys_clk);
        rdc(12'h004, 32'h20);
        cpu_idle <= 1'b0;
        chk(halts, 2);
        // counter wrap in counter mode blocks the next start
        wr(12'h000, 32'ha014);
        wr(12'h000, 32'ha114);
        pulse(2);
        pulse(0);
        rdc(12'h004, 32'h10);
        wr(12'h000, 32'ha114);
        chk(starts, 4);
        pulse(3);
        rdc(12'h000, 32'h0);
        rdc(12'h004, 32'h0);
        // faults evaluate with the engine off, then block program-write with the engine on
        txa_busy <= 1'b1;
        key_bad <= 1'b1;
        rdc(12'h004, 32'h42);
        wr(12'h000, 32'h8000);
        wr(12'h008, 32'h103);
        rdc(12'h008, 32'h102);
        {txa_busy, key_bad} <= 2'b00;
        wr(12'h000, 32'h8090);
        wr(12'h008, 32'h103);
        rdc(12'h008, 32'h102);
        wr(12'h000, 32'h8000);
        // page 1 is locked in the one-time array
        for (int i = 0; i < 16; i++) begin
            wr(12'h008, i * 2);
            rdc(12'h004, {31'h0, i > 8 || i == 1});
            chk(sreq.page, i);
        end
        wr(12'h008, 32'h003);
        rdc(12'h008, 32'h002);
        chk(sreq.req, 32'h0);
        wr(12'h008, 32'h142);
        wr(12'h008, 32'h143);
        chk({sreq.req, sreq.write, sreq.target_ram}, 32'h7);
        pulse(1);
        rdc(12'h008, 32'h142);
        chk(irqs, 1);
        wr(12'h008, 32'h160);
        rdc(12'h004, 32'h83);
        pulse(1);
        rdc(12'h008, 32'h140);
        chk(irqs, 2);
        marker <= 1'b1;
        rdc(12'h008, 32'h1c0);
        // unmapped word reads zero and ignores writes
        wr(12'h00c, 32'hffff);
        rdc(12'h00c, 32'h0);
        rdc(12'h000, 32'h8000);
        test_done();
    end
endmodule
